// [hw/rec_reset_entry.sv]
/*
 * Reset entry controller: power-on and manual reset pins, watchdog
 * power-on request, CPU and peripheral reset, vector select, pin direction.
 * Assumes one 125 MHz clock, synchronous active-high RST, an external
 * supervisor driving the power-on pin and a pin function controller.
 */
`timescale 1ns/1ps
`default_nettype none
module rec_reset_entry
    import rec_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Reset pins
    input wire logic POWER_ON_RESET_N,
    input wire logic MANUAL_RESET_N,
    // Watchdog unit
    input wire logic WDT_POR_REQ,
    output logic WDT_OVF_FLAG_CLR,
    // CPU and peripherals
    output logic CPU_RESET,
    output logic PERIPH_RESET,
    output logic BANK_NUMBER_CLR,
    output logic EXC_START,
    output logic VECTOR_SEL,
    output logic [31:0] VECTOR_ADDR,
    // Pin function controller
    input wire logic [NUM_PINS-1:0] PFC_DIR,
    output logic [NUM_PINS-1:0] PIN_OE
);
    rec_qual_if qif [2] ();
    logic [1:0] pins_n;
    rec_state_t state_ff, nxt_state;
    logic vsel_ff, nxt_vsel;
    logic [NUM_PINS-1:0] hold_ff, nxt_hold;
    logic por_low, manual_reset_n_low, manual_reset_n_qual, in_manual_reset_n;

    // One qualifier per reset pin
    assign pins_n = {MANUAL_RESET_N, POWER_ON_RESET_N};
    for (genvar g = 0; g < 2; g++) begin : g_qual
        rec_pin_qual u_qual (
            .clk(CLK),
            .rst(RST),
            .pin_n(pins_n[g]),
            .q(qif[g])
        );
    end
    assign por_low = qif[0].low;
    assign manual_reset_n_low = qif[1].low;
    assign manual_reset_n_qual = qif[1].qual;
    assign in_manual_reset_n = (state_ff == REC_MANUAL_RESET_N);

    // Power-on or watchdog first, then manual
    always_comb begin
        nxt_state = state_ff;
        nxt_vsel = vsel_ff;
        nxt_hold = hold_ff;
        if (por_low || WDT_POR_REQ) begin
            nxt_state = REC_POR;
            nxt_vsel = 1'b0;
            nxt_hold = MUX_RESET_DIR;  // pin controller is reset too
        end else begin
            case (state_ff)
                REC_POR: begin
                    nxt_state = REC_EXC;
                end
                REC_RUN: begin
                    nxt_hold = PFC_DIR;
                    if (manual_reset_n_qual) begin
                        nxt_state = REC_MANUAL_RESET_N;
                    end
                end
                REC_MANUAL_RESET_N: begin
                    if (!manual_reset_n_low) begin
                        nxt_state = REC_EXC;
                        nxt_vsel = 1'b1;
                    end
                end
                default: begin
                    nxt_state = REC_RUN;
                end
            endcase
        end
    end

    // Synchronous reset behaves like a power-on reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= REC_POR;
            vsel_ff <= 1'b0;
            hold_ff <= PFC_HOLD_RST;
        end else begin
            state_ff <= nxt_state;
            vsel_ff <= nxt_vsel;
            hold_ff <= nxt_hold;
        end
    end

    // Reset outputs decoded from the state register; vector from vsel_ff, flag clear from por_low and WDT_POR_REQ
    assign CPU_RESET = (state_ff == REC_POR) || in_manual_reset_n;
    assign PERIPH_RESET = (state_ff == REC_POR);
    assign BANK_NUMBER_CLR = in_manual_reset_n;
    assign EXC_START = (state_ff == REC_EXC);
    assign VECTOR_SEL = vsel_ff;
    assign VECTOR_ADDR = vsel_ff ? MANUAL_RESET_N_VEC_ADDR : POR_VEC_ADDR;
    assign WDT_OVF_FLAG_CLR = por_low && WDT_POR_REQ;

    // Direction per pin kind; manual reset freezes muxed pins, no glitch to input
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        logic [1:0] kind;
        assign kind = PIN_KIND_MAP[2*p +: 2];
        always_comb begin
            if (kind == PIN_KIND_IN) begin
                PIN_OE[p] = 1'b0;
            end else if (kind == PIN_KIND_OUT) begin
                PIN_OE[p] = 1'b1;
            end else if (state_ff == REC_POR) begin
                PIN_OE[p] = MUX_RESET_DIR[p];
            end else if (state_ff == REC_RUN) begin
                PIN_OE[p] = PFC_DIR[p];
            end else begin
                PIN_OE[p] = hold_ff[p];
            end
        end
    end

    // Checks
    logic [NUM_PINS-1:0] mux_mask, ded_out_mask;
    always_comb begin
        mux_mask = '0;
        ded_out_mask = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            mux_mask[i] = (PIN_KIND_MAP[2*i +: 2] == PIN_KIND_MUX);
            ded_out_mask[i] = (PIN_KIND_MAP[2*i +: 2] == PIN_KIND_OUT);
        end
    end

    property p_por_enter;
        @(posedge CLK) disable iff (RST) por_low |=> (state_ff == REC_POR);
    endproperty
    a_por_enter: assert property (p_por_enter) else $error("power-on reset not entered");

    property p_por_init;
        @(posedge CLK) disable iff (RST) por_low |=> PERIPH_RESET && CPU_RESET && !EXC_START;
    endproperty
    a_por_init: assert property (p_por_init) else $error("power-on reset outputs wrong");

    property p_por_first;
        @(posedge CLK) disable iff (RST) por_low |=> !in_manual_reset_n;
    endproperty
    a_por_first: assert property (p_por_first) else $error("manual reset beat power-on");

    property p_manual_reset_n_qual;
        @(posedge CLK) disable iff (RST) $rose(in_manual_reset_n) |-> $past(manual_reset_n_qual);
    endproperty
    a_manual_reset_n_qual: assert property (p_manual_reset_n_qual) else $error("short manual pulse accepted");

    property p_manual_reset_n_keep;
        @(posedge CLK) disable iff (RST) in_manual_reset_n |-> BANK_NUMBER_CLR && CPU_RESET && !PERIPH_RESET;
    endproperty
    a_manual_reset_n_keep: assert property (p_manual_reset_n_keep) else $error("manual reset scope wrong");

    property p_manual_reset_n_exc;
        @(posedge CLK) disable iff (RST)
            in_manual_reset_n && !manual_reset_n_low && !por_low && !WDT_POR_REQ |=> EXC_START ##1 !EXC_START;
    endproperty
    a_manual_reset_n_exc: assert property (p_manual_reset_n_exc) else $error("manual exception not started");

    property p_vec;
        @(posedge CLK) disable iff (RST)
            EXC_START |-> (VECTOR_ADDR == (VECTOR_SEL ? MANUAL_RESET_N_VEC_ADDR : POR_VEC_ADDR))
                && (VECTOR_SEL == $past(in_manual_reset_n));
    endproperty
    a_vec: assert property (p_vec) else $error("wrong exception vector");

    property p_ded_pins;
        @(posedge CLK) disable iff (RST) ((PIN_OE & ~mux_mask) == ded_out_mask);
    endproperty
    a_ded_pins: assert property (p_ded_pins) else $error("dedicated pin direction wrong");

    property p_mux_hold;
        @(posedge CLK) disable iff (RST)
            $rose(in_manual_reset_n) |-> ((PIN_OE & mux_mask) == ($past(PFC_DIR) & mux_mask));
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("muxed pin direction not held");

    property p_wdt_clr;
        @(posedge CLK) disable iff (RST)
            por_low && WDT_POR_REQ |-> WDT_OVF_FLAG_CLR ##1 (state_ff == REC_POR) && !VECTOR_SEL;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog flag not cleared");

    property p_qual_len;
        @(posedge CLK) disable iff (RST) $rose(manual_reset_n_qual) |-> manual_reset_n_low && $past(manual_reset_n_low, 19);
    endproperty
    a_qual_len: assert property (p_qual_len) else $error("manual qualified too early");

    c_por_exc: cover property (@(posedge CLK) disable iff (RST) EXC_START && !VECTOR_SEL);
    c_manual_reset_n_exc: cover property (@(posedge CLK) disable iff (RST) EXC_START && VECTOR_SEL);
    c_both: cover property (@(posedge CLK) disable iff (RST) WDT_OVF_FLAG_CLR);
    c_manual_reset_n_abort: cover property (@(posedge CLK) disable iff (RST) in_manual_reset_n ##1 por_low);
endmodule
`default_nettype wire

// [hw/rec_pkg.sv]
/*
 * Shared constants and types of the reset entry controller.
 * Assumes a single 125 MHz system clock; no software-visible registers.
 */
package rec_pkg;

    // System clock period and documented low-time figures
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_LOW_TCYC = 20;                // Least low time, in clock cycles
    localparam int OSC_SETTLE_MS = 10;               // Kept by the supervisor, not checked here
    localparam int LOW_CNT_W = 5;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_MIN = 5'h14;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_RST = 5'h00;

    // Exception vector table addresses for power-on and manual reset
    localparam logic [31:0] POR_VEC_ADDR = 32'h0000_0000;
    localparam logic [31:0] MANUAL_RESET_N_VEC_ADDR = 32'h0000_0008;

    // Pin map: 2 bits per pin, kinds below
    localparam int NUM_PINS = 8;
    localparam logic [1:0] PIN_KIND_IN = 2'h0;
    localparam logic [1:0] PIN_KIND_OUT = 2'h1;
    localparam logic [1:0] PIN_KIND_MUX = 2'h2;
    localparam logic [2*NUM_PINS-1:0] PIN_KIND_MAP = 16'haa41;
    localparam logic [NUM_PINS-1:0] MUX_RESET_DIR = 8'h00;  // Inputs after power-on reset
    localparam logic [NUM_PINS-1:0] PFC_HOLD_RST = 8'h00;

    // Reset entry states
    typedef enum logic [1:0] {
        REC_RUN,
        REC_POR,
        REC_MANUAL_RESET_N,
        REC_EXC
    } rec_state_t;

endpackage

// [hw/rec_qual_if.sv]
/*
 * Carrier between a reset pin qualifier and the reset entry controller.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface rec_qual_if;
    logic low;     // Filtered pin level is low
    logic qual;    // Low for at least the least low time
    modport qual_src (output low, output qual);
    modport qual_dst (input low, input qual);
endinterface
`default_nettype wire

// [hw/rec_pin_qual.sv]
/*
 * Synchroniser and low-time counter for one active-low reset pin.
 * Assumes the pin is asynchronous to CLK; reset is synchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none
module rec_pin_qual
    import rec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and result
    input wire logic pin_n,
    rec_qual_if.qual_src q
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_s1, nxt_s2, nxt_s3, nxt_lvl;
    logic [LOW_CNT_W-1:0] cnt_ff, nxt_cnt;

    // Level moves only once stages two and three agree
    always_comb begin
        nxt_s1 = pin_n;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
        if (lvl_ff) begin
            nxt_cnt = LOW_CNT_RST;
        end else if (cnt_ff < LOW_CNT_MIN) begin
            nxt_cnt = cnt_ff + 5'h01;
        end else begin
            nxt_cnt = cnt_ff;          // Saturates, no wrap
        end
    end

    // Reset assumes the pin low so nothing qualifies early
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            lvl_ff <= 1'b0;
            cnt_ff <= LOW_CNT_RST;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            lvl_ff <= nxt_lvl;
            cnt_ff <= nxt_cnt;
        end
    end

    assign q.low = ~lvl_ff;
    assign q.qual = ~lvl_ff && (cnt_ff >= LOW_CNT_MIN);
endmodule
`default_nettype wire

// [verification/rec_supervisor.sv]
/*
 * Behavioural reset supervisor driving both active-low reset pins.
 * Assumes the bench calls hold_low from its own thread on CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module rec_supervisor
    import rec_pkg::*;
#(
    parameter int SETTLE_CYC = 40  // Settling hold, shortened from 10 ms
)
(
    // Clock
    input wire logic clk,
    // Reset pins
    output logic por_n,
    output logic manual_reset_n_n
);
    // Power-up: pin low through the settling hold
    initial begin
        por_n = 1'b0;
        manual_reset_n_n = 1'b1;
        repeat (SETTLE_CYC) @(posedge clk);
        #1 por_n = 1'b1;
    end

    // Low pulse of n cycles; pulled up again afterwards
    task automatic hold_low(input bit manual, input int n);
        @(posedge clk);
        #1;
        if (manual) manual_reset_n_n = 1'b0; else por_n = 1'b0;
        repeat (n) @(posedge clk);
        #1;
        if (manual) manual_reset_n_n = 1'b1; else por_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// [verification/rec_reset_entry_test.sv]
/*
 * Self-checking bench of the reset entry controller.
 * Assumes rec_supervisor drives the pins; expectations are queued.
 */
`timescale 1ns/1ps
`default_nettype none
module rec_reset_entry_test
    import rec_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por_n, manual_reset_n_n, wdt_req, ovf_clr, cpu_rst, per_rst, bank_clr, exc, vsel;
    logic [31:0] vaddr;
    logic [NUM_PINS-1:0] pfc_dir, oe;
    logic [7:0] rnd = 8'h1e;
    logic exp_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    rec_supervisor rec_supervisor_i (.clk(clk), .por_n(por_n), .manual_reset_n_n(manual_reset_n_n));
    rec_reset_entry rec_reset_entry_i (.CLK(clk), .RST(rst), .POWER_ON_RESET_N(por_n),
        .MANUAL_RESET_N(manual_reset_n_n), .WDT_POR_REQ(wdt_req), .WDT_OVF_FLAG_CLR(ovf_clr),
        .CPU_RESET(cpu_rst), .PERIPH_RESET(per_rst), .BANK_NUMBER_CLR(bank_clr),
        .EXC_START(exc), .VECTOR_SEL(vsel), .VECTOR_ADDR(vaddr), .PFC_DIR(pfc_dir),
        .PIN_OE(oe));

    always #4 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Dedicated pins fixed, muxed pins follow the held direction
    function automatic logic [7:0] exp_oe(input logic [7:0] held);
        logic [7:0] r;
        logic [1:0] k;
        for (int i = 0; i < NUM_PINS; i++) begin
            k = PIN_KIND_MAP[2*i +: 2];
            r[i] = (k == PIN_KIND_OUT) ? 1'b1 : ((k == PIN_KIND_MUX) ? held[i] : 1'b0);
        end
        return r;
    endfunction

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Wait, bounded, until every queued exception start was seen
    task automatic wait_exc(input string tn);
        for (int i = 0; i < 80 && exp_q.size() > 0; i++) @(posedge clk);
        cmp_bit("exception start seen", 1'b1, exp_q.size() == 0);
        exp_q.delete();
        repeat (2) @(posedge clk);
        #1 $display("test %s done", tn);
    endtask

    // Monitor: each exception start takes the oldest expected vector
    always @(posedge clk) begin
        if (exc === 1'b1) begin
            if (exp_q.size() == 0) cmp_bit("unexpected exception start", 1'b0, 1'b1);
            else begin
                cmp_bit("vector select", exp_q[0], vsel);
                cmp_word("vector address", exp_q[0] ? MANUAL_RESET_N_VEC_ADDR : POR_VEC_ADDR, vaddr);
                void'(exp_q.pop_front());
            end
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        logic [7:0] held;
        wdt_req = 1'b0;
        pfc_dir = 8'h00;
        exp_q.push_back(1'b0);
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        wait_exc("power_up");
        cmp_bit("cpu reset idle", 1'b0, cpu_rst);
        cmp_bit("periph reset idle", 1'b0, per_rst);
        // Power-on pulse of the least low time
        exp_q.push_back(1'b0);
        fork
            rec_supervisor_i.hold_low(1'b0, MIN_LOW_TCYC);
            begin
                repeat (10) @(posedge clk);
                #1 cmp_bit("cpu reset por", 1'b1, cpu_rst);
                cmp_bit("periph reset por", 1'b1, per_rst);
                cmp_word("pin oe por", {24'h0, exp_oe(MUX_RESET_DIR)}, {24'h0, oe});
            end
        join
        wait_exc("power_on");
        // Manual reset, muxed directions from random values
        for (int t = 0; t < 3; t++) begin
            rnd = lfsr(rnd);
            pfc_dir = rnd;
            held = rnd;
            #1 cmp_word("pin oe run", {24'h0, exp_oe(held)}, {24'h0, oe});
            exp_q.push_back(1'b1);
            fork
                rec_supervisor_i.hold_low(1'b1, MIN_LOW_TCYC + 10);
                begin
                    repeat (28) @(posedge clk);
                    #1 cmp_bit("cpu reset manual", 1'b1, cpu_rst);
                    cmp_bit("periph reset manual", 1'b0, per_rst);
                    cmp_bit("bank clear manual", 1'b1, bank_clr);
                    rnd = lfsr(rnd);
                    pfc_dir = rnd;
                    #1 cmp_word("pin oe manual", {24'h0, exp_oe(held)}, {24'h0, oe});
                end
            join
            wait_exc("manual");
        end
        // Too short manual low is ignored
        fork
            rec_supervisor_i.hold_low(1'b1, 10);
            for (int i = 0; i < 20; i++) begin
                @(posedge clk);
                #1 cmp_bit("cpu reset short manual", 1'b0, cpu_rst);
            end
        join
        $display("test short_manual done");
        // Manual while power-on low: power-on wins
        exp_q.push_back(1'b0);
        fork
            rec_supervisor_i.hold_low(1'b0, 40);
            begin
                repeat (2) @(posedge clk);
                rec_supervisor_i.hold_low(1'b1, 30);
            end
            begin
                repeat (30) @(posedge clk);
                #1 cmp_bit("bank clear under por", 1'b0, bank_clr);
                cmp_bit("periph reset under por", 1'b1, per_rst);
            end
        join
        wait_exc("precedence");
        // Watchdog request alone, then with power-on pin low
        exp_q.push_back(1'b0);
        @(posedge clk);
        #1 wdt_req = 1'b1;
        repeat (3) @(posedge clk);
        #1 cmp_bit("periph reset wdt", 1'b1, per_rst);
        cmp_bit("flag clear wdt only", 1'b0, ovf_clr);
        fork
            rec_supervisor_i.hold_low(1'b0, MIN_LOW_TCYC);
            begin
                repeat (8) @(posedge clk);
                #1 cmp_bit("flag clear both", 1'b1, ovf_clr);
                wdt_req = 1'b0;
            end
        join
        wait_exc("watchdog");
        stop_test();
    end
endmodule
`default_nettype wire
